// ---- hdl/status_cmd.sv ----
// Serial command interpreter for indirect status writes, status lock and
// deep sleep entry of a serial flash. The serial shifter runs on SCK; all
// effects happen on MCLK once the raised chip select has been seen.
// Assumes SCK stays still while CS_N is high and during RESET.
//
// Contract
// - Opcode 71h, address byte 01h-05h, then one data byte into that status byte.
// - Indirect write executes only when the write enable latch or the volatile enable is set.
// - Volatile enable 50h keeps the latch, allows only the next status write.
// - Every byte takes eight clocks on SI, most significant bit first.
// - More than one data byte before chip select rises writes nothing.
// - Clocks 0-7 opcode, 8-15 address, 16-23 data bit 7 down to 0.
// - Write or lock ending off a byte boundary aborts, nothing changes.
// - Address 00h or 06h-FFh writes nothing, latch cleared at chip select rise.
// - Lock executes only with the write enable latch set.
// - Lock needs 4Dh then 67h; any other bytes or order abort.
// - Valid lock with both lock bits 11 freezes status bytes for good.
// - Deep sleep opcode with power-down select set enters deep sleep.
// - Deep sleep ignores every command except resume and the two resets.
// - Entry starts at chip select rise, ends within the entry time; the code starts its 250-cycle count up to three MCLK cycles after the rise.
// - Deep sleep opcode is ignored while a program or erase runs.
// - Deep sleep opcode is eight clocks, no address or data; the code accepts any whole number of bytes up to seven.
// - Deep sleep opcode ending off a byte boundary aborts.
// - Power-down select clear sends the opcode into ultra sleep instead.
`timescale 1ns/100ps
`default_nettype none
`include "status_cmd_map.svh"

module status_cmd
  import status_cmd_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        SI,
  input  wire logic        BUSY,
  input  wire logic        WAKE,
  output logic [39:0]      STATUS,
  output logic             LOCKED,
  output logic             DEEP_SLEEP,
  output logic             ULTRA_SLEEP
);

  // ===================================================================
  // Timing
  // Longest time rounds down, never below one cycle
  localparam int DEEP_RAW = `DEEP_ENTRY_NS * `MCLK_MHZ / 1000;
  localparam int DEEP_CYC = (DEEP_RAW < 1) ? 1 : DEEP_RAW;
  localparam logic [8:0] DEEP_LAST = 9'(DEEP_CYC - 1);

  // ===================================================================
  // Helpers
  // Address lies inside the implemented status bytes
  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a >= `STAT_ADDR_FIRST) && (a <= `STAT_ADDR_LAST);
  endfunction

  // Byte index of a valid address
  function automatic logic [2:0] stat_index(input logic [7:0] a);
    stat_index = a[2:0] - 3'h1;
  endfunction

  // ===================================================================
  // Link side: bit counter and byte capture on SCK
  link_t lq;
  link_t ln;
  logic  first_q;
  logic  [5:0] c;

  // Marks the next SCK edge as the first of a frame
  always_ff @(posedge SCK or posedge CS_N or posedge RESET) begin
    if (CS_N || RESET) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Bytes shift in most significant bit first, eight clocks each
  always_comb begin
    c = first_q ? 6'h00 : lq.fr.cnt;
    ln = lq;
    ln.sh = {lq.sh[6:0], SI};
    ln.fr.cnt = (c == `BITS_SAT) ? c : c + 6'h01;
    if (first_q) begin
      ln.fr.tog = ~lq.fr.tog;
    end
    // Bit 7, 15 and 23 close opcode, address and data
    if (c == 6'd7) begin
      ln.fr.cmd = {lq.sh[6:0], SI};
    end
    if (c == 6'd15) begin
      ln.fr.b1 = {lq.sh[6:0], SI};
    end
    if (c == 6'd23) begin
      ln.fr.b2 = {lq.sh[6:0], SI};
    end
  end

  // Reset only while SCK stands still, so release cannot race an edge
  always_ff @(posedge SCK or posedge RESET) begin
    if (RESET) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  // ===================================================================
  // System side decode
  // The frame is read only after CS_N has passed two flops; SCK has
  // stopped by then, so the snapshot is static (quasi-static handoff).
  ctl_t   q;
  ctl_t   n;
  frame_t fr;
  logic   cs_rise;
  logic   fresh;
  logic   byte_ok;
  logic   awake;
  logic   go;
  logic   wr_full;
  logic   wr_go;
  logic   lock_ok;
  logic   perm;

  assign fr      = lq.fr;
  assign cs_rise = q.cs_s & ~q.cs_d;
  assign fresh   = fr.tog != q.seen;
  assign byte_ok = fr.cnt[2:0] == 3'h0;
  assign awake   = q.pwr == PWR_ON;
  assign go      = cs_rise && fresh && byte_ok && awake;
  assign perm    = q.stat[0][`WEL_BIT] || q.vol;
  // Exactly three bytes; a second data byte spoils the write
  assign wr_full = go && (fr.cmd == `CMD_STAT_WR_IND) && (fr.cnt == `BITS_FULL);
  assign wr_go   = wr_full && addr_valid(fr.b1) && perm && !q.locked;
  // Both keys in order, latch set
  assign lock_ok = go && (fr.cmd == `CMD_STAT_LOCK) && (fr.cnt == `BITS_FULL)
                   && q.stat[0][`WEL_BIT]
                   && (fr.b1 == `LOCK_KEY_FIRST) && (fr.b2 == `LOCK_KEY_SECOND);

  // ===================================================================
  // Next state
  always_comb begin
    n = q;
    n.cs_m = CS_N;
    n.cs_s = q.cs_m;
    n.cs_d = q.cs_s;
    if (cs_rise) begin
      n.seen = fr.tog;
    end

    // Enables: first byte is the opcode, any whole number of bytes up to seven accepted
    if (go && fr.cmd == `CMD_WRITE_EN) begin
      n.stat[0][`WEL_BIT] = 1'b1;
    end
    if (go && fr.cmd == `CMD_VOL_WRITE_EN) begin
      n.vol = 1'b1;
    end

    // Indirect write: store, then drop both permissions
    if (wr_go) begin
      n.stat[stat_index(fr.b1)] = fr.b2;
    end
    if (wr_full && addr_valid(fr.b1) && perm) begin
      n.stat[0][`WEL_BIT] = 1'b0;
      n.vol = 1'b0;
    end
    // Undefined address: nothing written, latch still cleared
    if (wr_full && !addr_valid(fr.b1)) begin
      n.stat[0][`WEL_BIT] = 1'b0;
      n.vol = 1'b0;
    end

    // Lock freezes only when both lock bits are already armed
    if (lock_ok) begin
      if ({q.stat[1][`LOCK_HIGH_BIT], q.stat[0][`LOCK_LOW_BIT]} == `LOCK_ARMED) begin
        n.locked = 1'b1;
      end
      n.stat[0][`WEL_BIT] = 1'b0;
      n.vol = 1'b0;
    end

    // Power state
    unique case (q.pwr)
      PWR_ON: begin
        // Ignored while busy; the host retries later
        if (go && fr.cmd == `CMD_DEEP_SLEEP && !BUSY) begin
          n.pwr = PWR_ENTER;
          n.ultra_tgt = !q.stat[3][`PDS_BIT];
          n.tmr = 9'h000;
        end
      end
      PWR_ENTER: begin
        n.tmr = q.tmr + 9'h001;
        if (q.tmr == DEEP_LAST) begin
          n.pwr = q.ultra_tgt ? PWR_ULTRA : PWR_DEEP;
        end
      end
      PWR_DEEP: begin
        // Resume and resets live elsewhere and arrive as WAKE
        if (WAKE) begin
          n.pwr = PWR_ON;
        end
      end
      PWR_ULTRA: begin
        if (WAKE) begin
          n.pwr = PWR_ON;
        end
      end
    endcase
    n.deep_o = n.pwr == PWR_DEEP;
    n.ultra_o = n.pwr == PWR_ULTRA;

    // Busy mirrors the self-timed engine every cycle
    n.stat[0][`BUSY_BIT] = BUSY;
  end

  // ===================================================================
  // State register
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      q <= '0;
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.cs_d <= 1'b1;
      q.stat <= {5{`STAT_RST}};
      q.pwr <= PWR_ON;
    end else begin
      q <= n;
    end
  end

  // ===================================================================
  // Outputs, all straight from flops
  assign STATUS      = q.stat;
  assign LOCKED      = q.locked;
  assign DEEP_SLEEP  = q.deep_o;
  assign ULTRA_SLEEP = q.ultra_o;

  // ===================================================================
  // Checks
  a_write_lands: assert property (@(posedge MCLK) disable iff (RESET)
    wr_go |=> q.stat[$past(stat_index(fr.b1))] == $past(fr.b2)
              || $past(stat_index(fr.b1)) == 3'h0)
    else $error("indirect write data not stored");

  a_write_needs_perm: assert property (@(posedge MCLK) disable iff (RESET)
    (!$stable(q.stat[4:1])) |-> $past(perm) && $past(wr_full))
    else $error("status byte changed without permission");

  a_vol_keeps_latch: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_VOL_WRITE_EN) |=> q.vol && $stable(q.stat[0][`WEL_BIT]))
    else $error("volatile enable disturbed the latch");

  a_extra_byte: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_STAT_WR_IND && fr.cnt > `BITS_FULL) |=> $stable(q.stat[4:1]))
    else $error("write with extra data byte changed a status byte");

  a_partial_abort: assert property (@(posedge MCLK) disable iff (RESET)
    (cs_rise && !byte_ok && !BUSY) |=> $stable(q.stat) && $stable(q.vol) && $stable(q.locked))
    else $error("partial byte frame changed state");

  a_bad_addr: assert property (@(posedge MCLK) disable iff (RESET)
    (wr_full && !addr_valid(fr.b1)) |=> !q.stat[0][`WEL_BIT] && $stable(q.stat[4:1]))
    else $error("bad address not handled");

  a_lock_keys: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(q.locked) |-> $past(fr.b1) == `LOCK_KEY_FIRST && $past(fr.b2) == `LOCK_KEY_SECOND
                        && $past(q.stat[0][`WEL_BIT]))
    else $error("lock taken without keys or latch");

  a_lock_freezes: assert property (@(posedge MCLK) disable iff (RESET)
    q.locked |=> q.locked && $stable(q.stat[4:1]))
    else $error("locked status byte changed");

  a_sleep_ignores: assert property (@(posedge MCLK) disable iff (RESET)
    (q.pwr != PWR_ON && !WAKE) |=> $stable(q.stat[4:1]) && $stable(q.vol)
                                   && $stable(q.stat[0][`WEL_BIT]))
    else $error("command acted during sleep");

  a_entry_time: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(q.pwr == PWR_ENTER) |-> ##[DEEP_CYC:DEEP_CYC] (q.deep_o || q.ultra_o))
    else $error("sleep entry time wrong");

  a_busy_blocks: assert property (@(posedge MCLK) disable iff (RESET)
    (q.pwr == PWR_ON && BUSY) |=> q.pwr == PWR_ON)
    else $error("sleep entered while busy");

  a_ultra_select: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_DEEP_SLEEP && !BUSY && !q.stat[3][`PDS_BIT])
      |=> q.pwr == PWR_ENTER && q.ultra_tgt)
    else $error("select bit clear did not aim at ultra sleep");

  // ===================================================================
  // Further checks
  // These watch the decode from the system side only. The link shifter
  // is left unchecked: SCK stops between frames, so a property clocked by
  // it would stay open across every idle gap and never settle.
  // Each check on a decoded frame looks one cycle past the decode edge, where the state
  // register has taken the effect of the frame.
  // BUSY comes from the program engine on MCLK and is not synchronised,
  // so its mirror in status byte 1 trails it by exactly one cycle.
  // Permissions are one-shot: any completed write or lock drops both, so
  // a host that retries must enable again first.

  a_write_no_perm: assert property (@(posedge MCLK) disable iff (RESET)
    (wr_full && addr_valid(fr.b1) && !perm)
      |=> $stable(q.stat[4:1]) && $stable(q.stat[0][7:2]))
    else $error("status byte written without a write enable");

  a_enable_sets: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_WRITE_EN) |=> q.stat[0][`WEL_BIT])
    else $error("write enable did not set the latch");

  a_vol_one_shot: assert property (@(posedge MCLK) disable iff (RESET)
    (wr_full && addr_valid(fr.b1) && perm) |=> !q.vol)
    else $error("volatile permission outlived its write");

  a_write_clears: assert property (@(posedge MCLK) disable iff (RESET)
    wr_go |=> !q.stat[0][`WEL_BIT] && !q.vol)
    else $error("write left a permission behind");

  a_lock_needs_latch: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_STAT_LOCK && !q.stat[0][`WEL_BIT]) |=> $stable(q.locked))
    else $error("lock taken without the latch");

  a_key_order: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_STAT_LOCK
     && (fr.b1 != `LOCK_KEY_FIRST || fr.b2 != `LOCK_KEY_SECOND)) |=> $stable(q.locked))
    else $error("lock taken with wrong keys");

  a_lock_unarmed: assert property (@(posedge MCLK) disable iff (RESET)
    (lock_ok && {q.stat[1][`LOCK_HIGH_BIT], q.stat[0][`LOCK_LOW_BIT]} != `LOCK_ARMED)
      |=> $stable(q.locked))
    else $error("lock taken with lock bits not armed");

  a_lock_clears: assert property (@(posedge MCLK) disable iff (RESET)
    lock_ok |=> !q.stat[0][`WEL_BIT] && !q.vol)
    else $error("lock left a permission behind");

  a_deep_select: assert property (@(posedge MCLK) disable iff (RESET)
    (go && fr.cmd == `CMD_DEEP_SLEEP && !BUSY && q.stat[3][`PDS_BIT])
      |=> q.pwr == PWR_ENTER && !q.ultra_tgt)
    else $error("select bit set did not aim at deep sleep");

  a_wake_exits: assert property (@(posedge MCLK) disable iff (RESET)
    ((q.pwr == PWR_DEEP || q.pwr == PWR_ULTRA) && WAKE)
      |=> q.pwr == PWR_ON && !q.deep_o && !q.ultra_o)
    else $error("wake did not leave sleep");

  a_enter_waits: assert property (@(posedge MCLK) disable iff (RESET)
    (q.pwr == PWR_ENTER && q.tmr != DEEP_LAST) |=> q.pwr == PWR_ENTER)
    else $error("sleep entry cut short");

  a_deep_from_enter: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(q.deep_o) |-> $past(q.pwr) == PWR_ENTER && !$past(q.ultra_tgt))
    else $error("deep sleep reached without entry");

  a_busy_mirror: assert property (@(posedge MCLK) disable iff (RESET)
    !$past(RESET) |-> q.stat[0][`BUSY_BIT] == $past(BUSY))
    else $error("busy flag does not follow the engine");

  a_partial_sleep: assert property (@(posedge MCLK) disable iff (RESET)
    (cs_rise && !byte_ok && q.pwr == PWR_ON) |=> q.pwr == PWR_ON)
    else $error("partial frame started sleep entry");

  a_flags_apart: assert property (@(posedge MCLK) disable iff (RESET)
    !(q.deep_o && q.ultra_o))
    else $error("both sleep flags high");

endmodule
`default_nettype wire

// ---- include/status_cmd_map.svh ----
// Constants of the status command interpreter: opcodes, addresses, bit
// positions, reset values and timing figures. Definitions only.
// Assumes inclusion by bare name from the design and bench files.
`ifndef STATUS_CMD_MAP_SVH
`define STATUS_CMD_MAP_SVH

// =====================================================================
// Opcodes
`define CMD_WRITE_EN      8'h06
`define CMD_VOL_WRITE_EN  8'h50
`define CMD_STAT_WR_IND   8'h71
`define CMD_STAT_LOCK     8'h6f
`define CMD_DEEP_SLEEP    8'hb9

// =====================================================================
// Lock verification bytes, first then second
`define LOCK_KEY_FIRST    8'h4d
`define LOCK_KEY_SECOND   8'h67
`define LOCK_ARMED        2'b11

// =====================================================================
// Status byte addresses (byte index is address minus one)
`define STAT_ADDR_FIRST   8'h01
`define STAT_ADDR_LAST    8'h05
`define STAT_RST          8'h00

// =====================================================================
// Field positions
`define WEL_BIT           1
`define BUSY_BIT          0
`define LOCK_LOW_BIT      7
`define LOCK_HIGH_BIT     0
`define PDS_BIT           7

// =====================================================================
// Frame bit counts
`define BITS_OPCODE       6'd8
`define BITS_FULL         6'd24
`define BITS_SAT          6'h3f

// =====================================================================
// Timing: longest deep sleep entry time and the system clock rate
`define DEEP_ENTRY_NS     2000
`define MCLK_MHZ          125

`endif

// ---- include/status_cmd_pkg.sv ----
// Types shared by the status command interpreter and its bench.
// Assumes the constants header sits in the same include folder.
`default_nettype none
package status_cmd_pkg;

  // Power state of the device
  typedef enum logic [1:0] {
    PWR_ON    = 2'b00,
    PWR_ENTER = 2'b01,
    PWR_DEEP  = 2'b10,
    PWR_ULTRA = 2'b11
  } pwr_t;

  // Snapshot of one serial frame, handed from link to system clock
  typedef struct packed {
    logic       tog;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [7:0] b1;
    logic [7:0] b2;
  } frame_t;

  // Link clock state
  typedef struct packed {
    frame_t     fr;
    logic [7:0] sh;
  } link_t;

  // System clock state
  typedef struct packed {
    logic            cs_m;
    logic            cs_s;
    logic            cs_d;
    logic            seen;
    logic [4:0][7:0] stat;
    logic            vol;
    logic            locked;
    pwr_t            pwr;
    logic            ultra_tgt;
    logic [8:0]      tmr;
    logic            deep_o;
    logic            ultra_o;
  } ctl_t;

endpackage
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// Host side of the serial link: drives chip select, serial clock and data.
// Assumes the bench calls send between frames only, one frame at a time.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  output logic CS_N,
  output logic SCK,
  output logic SI
);
  // ===================================================================
  // Idle link: clock parked low, chip select high
  initial begin
    CS_N = 1'b1;
    SCK  = 1'b0;
    SI   = 1'b0;
  end

  // Word is left aligned; only its top n bits go out, so short counts
  // let the bench cut a frame off mid-byte on purpose
  task automatic send(input logic [31:0] w, input int n);
    #3;
    CS_N = 1'b0;
    for (int i = 0; i < n; i++) begin
      SI = w[31-i];
      #15 SCK = 1'b1;
      #15 SCK = 1'b0;
    end
    #15 CS_N = 1'b1;
    SI = ~SI;                        // Released line must not keep the last bit
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_status_cmd.sv ----
// Self-checking bench for the status command interpreter.
// Assumes the host model owns the link; MCLK runs at 125 MHz.
`timescale 1ns/100ps
`default_nettype none

module tb_status_cmd;
  import status_cmd_pkg::*;
  logic        MCLK        = 1'b0;
  logic        RESET;       // Rises at time zero: the link side resets on its edge
  logic        BUSY        = 1'b0;
  logic        WAKE        = 1'b0;
  wire logic   SCK;
  wire logic   CS_N;
  wire logic   SI;
  logic [39:0] STATUS;
  logic        LOCKED;
  logic        DEEP_SLEEP;
  logic        ULTRA_SLEEP;
  logic [39:0] want_st     = 40'h0;
  int          mismatches  = 0;
  int          compares    = 0;
  int          cycles      = 0;

  // ===================================================================
  // Clock, design and host model
  initial begin
    forever #4 MCLK = ~MCLK;
  end

  status_cmd i_dut (.MCLK(MCLK), .RESET(RESET), .SCK(SCK), .CS_N(CS_N), .SI(SI),
    .BUSY(BUSY), .WAKE(WAKE), .STATUS(STATUS), .LOCKED(LOCKED),
    .DEEP_SLEEP(DEEP_SLEEP), .ULTRA_SLEEP(ULTRA_SLEEP));

  spi_host_model i_host (.CS_N(CS_N), .SCK(SCK), .SI(SI));

  // ===================================================================
  // Reporting
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Hang guard: the whole run needs well under 10000 cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict;
    end
  end

  // ===================================================================
  // Helpers: one frame, then six cycles so the result has landed;
  // results are looked at on the falling edge, clear of the update
  task automatic frame(input logic [31:0] w, input int n);
    @(posedge MCLK);
    i_host.send(w, n);
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
  endtask

  task automatic wren;
    frame(32'h06000000, 8);
    want_st[1] = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wren();
    frame({8'h71, a, d, 8'h00}, 24);
    want_st[8*(a-1) +: 8] = d;
    want_st[1] = 1'b0;
  endtask

  // Waits a fixed 262 cycles for sleep entry, then checks both sleep flags
  task automatic wait_flag(input logic ultra, input logic want);
    for (int k = 0; k < 262; k++) begin
      @(negedge MCLK);
    end
    chk({38'h0, ULTRA_SLEEP, DEEP_SLEEP}, {38'h0, ultra & want, ~ultra & want});
  endtask

  task automatic wake;
    @(posedge MCLK) WAKE <= 1'b1;
    @(posedge MCLK) WAKE <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk({38'h0, ULTRA_SLEEP, DEEP_SLEEP}, 40'h0);
  endtask

  task automatic do_reset;
    @(posedge MCLK) RESET <= 1'b1;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    want_st = 40'h0;
    @(negedge MCLK);
    chk(STATUS, 40'h0);
    chk({37'h0, LOCKED, DEEP_SLEEP, ULTRA_SLEEP}, 40'h0);
  endtask

  // ===================================================================
  // Scenarios
  task automatic t_write;
    frame(32'h7103a500, 24);
    chk(STATUS, want_st);
    wren();
    chk(STATUS, want_st);
    frame(32'h7103a500, 24);
    want_st[23:16] = 8'ha5;
    want_st[1] = 1'b0;
    chk(STATUS, want_st);
    frame(32'h71035a00, 24);
    chk(STATUS, want_st);
  endtask

  task automatic t_volatile;
    frame(32'h50000000, 8);
    chk(STATUS, want_st);
    frame(32'h71053c00, 24);
    want_st[39:32] = 8'h3c;
    chk(STATUS, want_st);
    frame(32'h7105c300, 24);
    chk(STATUS, want_st);
  endtask

  task automatic t_abort;
    wren();
    frame(32'h71021122, 32);
    chk(STATUS, want_st);
    frame(32'h71021100, 20);
    chk(STATUS, want_st);
    frame(32'h7107aa00, 24);
    want_st[1] = 1'b0;
    chk(STATUS, want_st);
    wren();
    frame(32'h7100aa00, 24);
    want_st[1] = 1'b0;
    chk(STATUS, want_st);
  endtask

  task automatic t_sleep;
    wr(8'h04, 8'h80);
    @(posedge MCLK) BUSY <= 1'b1;
    frame(32'hb9000000, 8);
    chk({39'h0, STATUS[0]}, 40'h1);
    wait_flag(1'b0, 1'b0);
    @(posedge MCLK) BUSY <= 1'b0;
    frame(32'hb9000000, 12);
    wait_flag(1'b0, 1'b0);
    frame(32'hb9000000, 8);
    wait_flag(1'b0, 1'b1);
    frame(32'h06000000, 8);
    chk(STATUS, want_st);
    wake();
    wr(8'h04, 8'h00);
    frame(32'hb9000000, 8);
    wait_flag(1'b1, 1'b1);
    wake();
  endtask

  task automatic t_lock;
    wr(8'h01, 8'h80);
    wren();
    frame(32'h6f4d6700, 24);
    want_st[1] = 1'b0;
    chk({STATUS[39:1], LOCKED}, {want_st[39:1], 1'b0});
    wr(8'h02, 8'h01);
    chk(STATUS, want_st);
    frame(32'h6f4d6700, 24);
    chk({39'h0, LOCKED}, 40'h0);
    wren();
    frame(32'h6f674d00, 24);
    chk({39'h0, LOCKED}, 40'h0);
    frame(32'h6f4d6000, 20);
    chk({STATUS[39:1], LOCKED}, {want_st[39:1], 1'b0});
    frame(32'h6f4d6700, 24);
    want_st[1] = 1'b0;
    chk({STATUS[39:1], LOCKED}, {want_st[39:1], 1'b1});
    wren();
    frame(32'h7103ff00, 24);
    chk({8'h0, STATUS[39:8]}, {8'h0, want_st[39:8]});
  endtask

  // ===================================================================
  // Main sequence
  initial begin
    RESET <= 1'b1;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    @(negedge MCLK);
    chk(STATUS, 40'h0);
    t_write();
    t_volatile();
    t_abort();
    t_sleep();
    do_reset();
    t_lock();
    give_verdict;
  end
endmodule
`default_nettype wire
